// ### pkg/standby_halt_pkg.sv
// Purpose: shared constants and types of the standby and halt controller
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: pin groups travel as packed structs
package standby_halt_pkg;
    localparam logic [7:0] HALT_OPCODE = 8'h01;
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned HOLD_TIME_US = 10;
    localparam int unsigned SETUP_TIME_MS = 10;
    localparam int unsigned HOLD_CYCLES = (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYCLES = (SETUP_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_HALT,
        ST_RAM_HOLD,
        ST_ALL_HOLD,
        ST_WAKE_RAM,
        ST_WAKE_ALL
    } pd_state_t;

    // pin enables and drive of the pins that power-down or halt reshapes
    typedef struct packed {
        logic bus_oe;
        logic bus_in_en;
        logic ports_in_en;
        logic t0_oe;
        logic t0_in_en;
        logic t1_in_en;
        logic reset_in_en;
        logic step_in_en;
        logic int_in_en;
        logic ea_in_en;
        logic pullup_en;
        logic strobe_oe;
        logic strobe_hold_idle;
        logic xtal_force_high;
    } pin_ctrl_t;
endpackage

// ### rtl/standby_halt_control.sv
// Purpose: standby and halt control for an 8-bit microcomputer core
// Assumes: pins synchronous to ref_clk_in; core consumes core_clk_en_out
// Notes: oscillator stop is modelled as a low clock enable to the core
// Behaviour
// - reset low then power_save_n low enters ram-hold power-down, oscillator off
// - power_save_n high then reset high restarts core at address zero
// - single_step_n low then power_save_n low enters all-state-hold power-down
// - power_save_n high then single_step_n high resumes with state intact
// - executing opcode 01h enters halt mode
// - halt keeps oscillator running but freezes internal clocks
// - halt leaves only on reset or interrupt request
// - reset release from halt restarts at address zero
// - interrupt wake with interrupts enabled runs one instruction then services
// - interrupt wake with interrupts disabled resumes sequentially, no service
// - power-down floats bus, ports, test pin zero, strobes; crystal output high
// - oscillator stopped disables control inputs and reset, step pull-ups
// - halt holds pins; reset and interrupt enabled, other control inputs (t1, step, ea) disabled
`timescale 1ns/100ps
module standby_halt_control (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic reset_n_in,
    input wire logic single_step_n_in,
    input wire logic power_save_n_in,
    input wire logic int_n_in,
    input wire logic instr_exec_in,
    input wire logic [7:0] opcode_in,
    input wire logic interrupts_enabled_state_in,
    output logic osc_run_out,
    output logic core_clk_en_out,
    output logic core_reset_out,
    output logic [11:0] restart_addr_out,
    output logic halted_out,
    output logic service_after_one_out,
    output logic int_service_block_out,
    output standby_halt_pkg::pin_ctrl_t pin_ctrl_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    standby_halt_pkg::pd_state_t state_q, state_d;
    logic svc_q, svc_d;
    logic blk_q, blk_d;
    logic crst_q, crst_d;
    standby_halt_pkg::pin_ctrl_t pins_d;
    logic osc_d, clk_en_d, halted_d;
    logic [11:0] restart_d;

    always_comb begin
        state_d = state_q;
        svc_d = svc_q;
        blk_d = blk_q;
        crst_d = !reset_n_in;
        case (state_q)
            standby_halt_pkg::ST_RUN: begin
                if (!power_save_n_in && !reset_n_in) begin
                    state_d = standby_halt_pkg::ST_RAM_HOLD;
                end else if (!power_save_n_in && !single_step_n_in) begin
                    state_d = standby_halt_pkg::ST_ALL_HOLD;
                end else if (instr_exec_in && opcode_in == standby_halt_pkg::HALT_OPCODE) begin
                    state_d = standby_halt_pkg::ST_HALT;
                end
                // any executed instruction retires a pending wake marker
                if (instr_exec_in) begin
                    svc_d = 1'b0;
                    blk_d = 1'b0;
                end
            end
            standby_halt_pkg::ST_HALT: begin
                if (!reset_n_in) begin
                    state_d = standby_halt_pkg::ST_RUN;
                    svc_d = 1'b0;
                    blk_d = 1'b0;
                end else if (!int_n_in) begin
                    state_d = standby_halt_pkg::ST_RUN;
                    svc_d = interrupts_enabled_state_in;
                    blk_d = !interrupts_enabled_state_in;
                end
            end
            standby_halt_pkg::ST_RAM_HOLD: begin
                // inputs are dead while stopped; only power_save_n wakes it
                crst_d = 1'b1;
                if (power_save_n_in) begin
                    state_d = standby_halt_pkg::ST_WAKE_RAM;
                end
            end
            standby_halt_pkg::ST_ALL_HOLD: begin
                // reset pin is dead while stopped, so core reset keeps its value
                crst_d = crst_q;
                if (power_save_n_in) begin
                    state_d = standby_halt_pkg::ST_WAKE_ALL;
                end
            end
            standby_halt_pkg::ST_WAKE_RAM: begin
                crst_d = 1'b1;
                if (reset_n_in) begin
                    state_d = standby_halt_pkg::ST_RUN;
                    crst_d = 1'b0;
                    svc_d = 1'b0;
                    blk_d = 1'b0;
                end
            end
            standby_halt_pkg::ST_WAKE_ALL: begin
                if (single_step_n_in) begin
                    state_d = standby_halt_pkg::ST_RUN;
                end
            end
            default: state_d = standby_halt_pkg::ST_RUN;
        endcase
    end

    // ----------------------------------------------------------------
    // output next values
    // ----------------------------------------------------------------
    always_comb begin
        // oscillator stops only while parked in a power-down state
        osc_d = !(state_d inside {standby_halt_pkg::ST_RAM_HOLD,
                                  standby_halt_pkg::ST_ALL_HOLD});
        clk_en_d = (state_d == standby_halt_pkg::ST_RUN);
        halted_d = (state_d == standby_halt_pkg::ST_HALT);
        restart_d = standby_halt_pkg::RESET_VECTOR;
    end

    // ----------------------------------------------------------------
    // pin control
    // ----------------------------------------------------------------
    always_comb begin
        pins_d = '1;
        pins_d.strobe_hold_idle = 1'b0;
        pins_d.xtal_force_high = 1'b0;
        case (state_d)
            standby_halt_pkg::ST_RAM_HOLD, standby_halt_pkg::ST_ALL_HOLD: begin
                pins_d = '0;
                pins_d.xtal_force_high = 1'b1;
            end
            standby_halt_pkg::ST_WAKE_RAM, standby_halt_pkg::ST_WAKE_ALL: begin
                // oscillator is back, control inputs and pull-ups live again, bus, port and t0 inputs still off, pins still floated
                pins_d = '0;
                pins_d.reset_in_en = 1'b1;
                pins_d.step_in_en = 1'b1;
                pins_d.int_in_en = 1'b1;
                pins_d.ea_in_en = 1'b1;
                pins_d.t1_in_en = 1'b1;
                pins_d.pullup_en = 1'b1;
            end
            standby_halt_pkg::ST_HALT: begin
                pins_d.t1_in_en = 1'b0;
                pins_d.step_in_en = 1'b0;
                pins_d.ea_in_en = 1'b0;
                pins_d.strobe_hold_idle = 1'b1;
            end
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= standby_halt_pkg::ST_RUN;
            svc_q <= 1'b0;
            blk_q <= 1'b0;
            crst_q <= 1'b1;
            osc_run_out <= 1'b1;
            core_clk_en_out <= 1'b0;
            halted_out <= 1'b0;
            pin_ctrl_out <= '0;
            restart_addr_out <= standby_halt_pkg::RESET_VECTOR;
        end else begin
            state_q <= state_d;
            svc_q <= svc_d;
            blk_q <= blk_d;
            crst_q <= crst_d;
            osc_run_out <= osc_d;
            core_clk_en_out <= clk_en_d;
            halted_out <= halted_d;
            pin_ctrl_out <= pins_d;
            restart_addr_out <= restart_d;
        end
    end

    assign core_reset_out = crst_q;
    assign service_after_one_out = svc_q;
    assign int_service_block_out = blk_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_halt_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_RUN && reset_n_in && power_save_n_in && instr_exec_in
        && opcode_in == standby_halt_pkg::HALT_OPCODE |=> halted_out && !core_clk_en_out)
        else $error("halt opcode did not halt");
    a_halt_osc_runs: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        halted_out |-> osc_run_out && !core_clk_en_out)
        else $error("halt stopped oscillator or left clocks on");
    a_halt_stays: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_HALT && reset_n_in && int_n_in |=> halted_out)
        else $error("halt released without cause");
    a_int_service: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_HALT && reset_n_in && !int_n_in
        |=> core_clk_en_out && service_after_one_out == $past(interrupts_enabled_state_in))
        else $error("interrupt wake wrong");
    a_di_wake: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_HALT && reset_n_in && !int_n_in
        && !interrupts_enabled_state_in |=> int_service_block_out && !service_after_one_out)
        else $error("disabled interrupt wake wrong");
    a_halt_reset: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_HALT && !reset_n_in
        |=> !halted_out && core_reset_out && restart_addr_out == standby_halt_pkg::RESET_VECTOR)
        else $error("reset did not release halt");
    a_ram_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_RUN && !reset_n_in && !power_save_n_in
        |=> !osc_run_out && pin_ctrl_out.xtal_force_high && !pin_ctrl_out.bus_oe)
        else $error("ram hold entry wrong");
    a_all_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_RUN && reset_n_in && !single_step_n_in
        && !power_save_n_in |=> !osc_run_out && !core_reset_out)
        else $error("all hold entry wrong");
    a_all_resume: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_WAKE_ALL && single_step_n_in && reset_n_in
        |=> core_clk_en_out && !core_reset_out)
        else $error("all-state wake did not resume");
    a_stop_inputs: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !osc_run_out |-> !pin_ctrl_out.reset_in_en && !pin_ctrl_out.pullup_en
        && !pin_ctrl_out.int_in_en && !core_clk_en_out)
        else $error("inputs live while stopped");
    a_halt_pins: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        halted_out |-> pin_ctrl_out.int_in_en && pin_ctrl_out.reset_in_en
        && !pin_ctrl_out.step_in_en && pin_ctrl_out.bus_oe)
        else $error("halt pin status wrong");
    a_ram_restart: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_q == standby_halt_pkg::ST_WAKE_RAM && !reset_n_in |=> core_reset_out)
        else $error("ram wake skipped reset");
endmodule

// ### bench/pin_sequencer.sv
// Purpose: external controller model that drives the reset, step and power-save pins
// Assumes: mode_in leaves run only for one mode at a time and returns to run between them
// Notes: the hold and setup gaps are scaled down to GAP cycles to keep runs short
`timescale 1ns/100ps
module pin_sequencer #(parameter int GAP = 4) (
    input wire logic ref_clk_in,
    input wire logic [1:0] mode_in,
    output logic reset_n_out,
    output logic single_step_n_out,
    output logic power_save_n_out
);
    // ----------------------------------------
    // mode 0 run, 1 ram hold, 2 all hold, 3 reset pin only
    // ----------------------------------------
    logic [1:0] cur_mode = 2'd0;
    initial begin
        reset_n_out = 1'b1;
        single_step_n_out = 1'b1;
        power_save_n_out = 1'b1;
        forever begin
            @(posedge ref_clk_in);
            // a later offset than the bench, so a new mode is read without a race
            #2;
            if (mode_in != cur_mode && cur_mode == 2'd0) begin
                reset_n_out = (mode_in == 2'd2);
                single_step_n_out = (mode_in != 2'd2);
                if (mode_in != 2'd3) begin
                    repeat (GAP) @(posedge ref_clk_in);
                    #2;
                    power_save_n_out = 1'b0;
                end
                cur_mode = mode_in;
            end else if (mode_in != cur_mode) begin
                power_save_n_out = 1'b1;
                repeat (GAP) @(posedge ref_clk_in);
                #2;
                reset_n_out = 1'b1;
                single_step_n_out = 1'b1;
                cur_mode = mode_in;
            end
        end
    end
endmodule

// ### bench/tb.sv
// Purpose: self-checking bench for standby_halt_control
// Assumes: outputs settle one cycle after the edge that causes them
// Notes: power-down pin sequences come from pin_sequencer
`timescale 1ns/100ps
module tb;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic int_n_in = 1'b1;
    logic instr_exec_in = 1'b0;
    logic [7:0] opcode_in = 8'h00;
    logic ie_in = 1'b0;
    logic [1:0] mode = 2'd0;
    logic reset_n, step_n, ps_n, osc_run, clk_en, core_rst, halted, svc, blk;
    logic [11:0] restart_addr;
    standby_halt_pkg::pin_ctrl_t pins;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int i;
    int seen;
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    pin_sequencer #(.GAP(4)) partner (.ref_clk_in(ref_clk_in), .mode_in(mode),
        .reset_n_out(reset_n), .single_step_n_out(step_n), .power_save_n_out(ps_n));
    standby_halt_control uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reset_n_in(reset_n),
        .single_step_n_in(step_n), .power_save_n_in(ps_n), .int_n_in(int_n_in),
        .instr_exec_in(instr_exec_in), .opcode_in(opcode_in),
        .interrupts_enabled_state_in(ie_in), .osc_run_out(osc_run), .core_clk_en_out(clk_en),
        .core_reset_out(core_rst), .restart_addr_out(restart_addr), .halted_out(halted),
        .service_after_one_out(svc), .int_service_block_out(blk), .pin_ctrl_out(pins));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic step(input int n = 1);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic exec_some(input logic [7:0] op, input int n);
        opcode_in = op;
        instr_exec_in = 1'b1;
        step(n);
        instr_exec_in = 1'b0;
        step();
    endtask
    task automatic pd_check(input logic ram);
        for (i = 0; i < 40 && osc_run !== 1'b0; i++) step();
        chk("osc in power-down", 0, osc_run);
        chk("clk_en in power-down", 0, clk_en);
        chk("pins in power-down", 32'h0001, pins);
        int_n_in = 1'b0;
        step(3);
        int_n_in = 1'b1;
        chk("osc after int", 0, osc_run);
        mode = 2'd0;
        seen = 0;
        // ram wake must pass through core reset, all-state wake never may
        for (i = 0; i < 60 && !(clk_en === 1'b1 && core_rst === 1'b0); i++) begin
            seen |= int'(core_rst === 1'b1);
            step();
        end
        chk("clk_en after wake", 1, clk_en);
        chk("core reset on wake", 32'(ram), seen);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h10d149b9));
        step(20);
        rst_in = 1'b0;
        step(2);
        chk("clk_en after reset", 1, clk_en);
        chk("pins after reset", 32'h3ffc, pins);
        for (i = 0; i < 8; i++) exec_some(8'($urandom_range(255, 2)), 1);
        chk("halted on other opcodes", 0, halted);
        for (int ie = 0; ie < 3; ie++) begin
            ie_in = ie[0];
            exec_some(standby_halt_pkg::HALT_OPCODE, 1);
            chk("halted", 1, halted);
            chk("clk_en in halt", 0, clk_en);
            chk("osc in halt", 1, osc_run);
            chk("halt input enables", 32'h0a, 32'(pins[8:4]));
            exec_some(8'($urandom_range(255, 2)), 3);
            chk("stay halted", 1, halted);
            int_n_in = ie[1];
            mode = {ie[1], ie[1]};
            step(4);
            int_n_in = 1'b1;
            chk("woken", 0, halted);
            chk("core reset", 32'(ie[1]), core_rst);
            chk("service after one", 32'(ie == 1), svc);
            chk("service block on di wake", 32'(ie == 0), blk);
            mode = 2'd0;
            exec_some(8'($urandom_range(255, 2)), 1);
            step(10);
            chk("service cleared", 0, svc);
            chk("service block cleared", 0, blk);
            chk("core running", 0, core_rst);
            chk("restart addr", 0, restart_addr);
        end
        mode = 2'd1;
        pd_check(1'b1);
        mode = 2'd2;
        pd_check(1'b0);
        report_and_stop();
    end
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
endmodule
